// ---- src/gtc_timer.sv ----
// Gated 16-bit timer/counter with prescaler, rollover flag and wake request
// Function
// [R1] 16-bit counter, byte writes update immediately
// [R2] Source bit picks instruction clock or pin
// [R3] Count external rising edges, sync or async
// [R4] Need a falling edge before first count
// [R5] Prescale count clock by 1, 2, 4, 8
// [R6] Hidden prescaler cleared on byte writes
// [R7] Enable bit starts crystal oscillator, runs asleep
// [R8] Crystal only with compatible main clock
// [R9] Oscillator pins forced input, read zero
// [R10] Software waits oscillator start-up before enabling
// [R11] Bypass mode counts unsynchronised, wakes core
// [R12] Mode switch may drop or add one
// [R13] Byte reads always return a valid value
// [R14] Software stops timer before writing counter
// [R15] Gate from pin or second comparator
// [R16] Gating acts only when gate enable set
// [R17] Invert bit flips gate for either source
// [R18] Wrap FFFF to 0000, set rollover flag
// [R19] Interrupt needs all three enables set
// [R20] Software clears the rollover flag
// [R21] Software clears counter and flag first
// [R22] Sleep counting only async; overflow wakes core
// [R23] Select codes map to 1, 2, 4, 8
// [R24] Counter holds while timer is off
// [R25] Gated count only at active level
`timescale 1ns/100ps
module gtc_timer
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Control and software access
   input wire gtc_pkg::gtc_ctrl_s timer_control_reg,
   input wire gtc_pkg::gtc_wr_s count_write,
   input wire gtc_pkg::gtc_irq_s irq_control,
   input wire logic sleep_mode,
   input wire logic main_clk_lp_compatible,
   input wire logic gate_source_select,
   input wire logic osc_out_pin_direction_sw,
   input wire logic osc_in_pin_direction_sw,
   input wire logic osc_out_port_bit_pin,
   input wire logic osc_in_port_bit_pin,
   // External pins and comparator
   input wire logic external_count_input,
   input wire logic gate_input_pin,
   input wire logic comparator2_out,
   // Count and status
   output logic [7:0] count_high_byte,
   output logic [7:0] count_low_byte,
   output logic rollover_flag,
   output logic irq_request,
   output logic wake_request,
   output logic crystal_osc_run,
   output logic osc_out_pin_direction,
   output logic osc_in_pin_direction,
   output logic osc_out_port_bit,
   output logic osc_in_port_bit
);
   gtc_pkg::gtc_ctrl_s ctl;
   logic [15:0] count;
   logic [15:0] next_count;
   logic [2:0] presc;
   logic [2:0] next_presc;
   logic [1:0] cy_div;
   logic [1:0] next_cy_div;
   logic ext_m, ext_s, ext_d;
   logic gpin_m, gpin_s, cmp_m, cmp_s;
   logic armed, next_armed;
   logic first_on, next_first_on;
   logic lvl_off, next_lvl_off;
   logic on_d;
   logic sync_pend, next_sync_pend;
   logic flag, next_flag;
   logic cy_en, ext_rise, ext_fall, wr_any, gate_act, gate_ok;
   logic src_tick, presc_tick, inc, sleep_ok;

   // Prescale terminal count for the 2-bit select
   function automatic logic [2:0] presc_last(input logic [1:0] sel);
      unique case (sel)
         gtc_pkg::PS_DIV1: presc_last = 3'h0;
         gtc_pkg::PS_DIV2: presc_last = 3'h1;
         gtc_pkg::PS_DIV4: presc_last = 3'h3;
         gtc_pkg::PS_DIV8: presc_last = 3'h7;
      endcase
   endfunction : presc_last

   assign ctl = timer_control_reg;

   // Pin synchronisers
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ext_m <= 1'b0;
         ext_s <= 1'b0;
         ext_d <= 1'b0;
         gpin_m <= 1'b0;
         gpin_s <= 1'b0;
         cmp_m <= 1'b0;
         cmp_s <= 1'b0;
         on_d <= 1'b0;
      end
      else
      begin
         ext_m <= external_count_input;
         ext_s <= ext_m;
         ext_d <= ext_s;
         gpin_m <= gate_input_pin;
         gpin_s <= gpin_m;
         cmp_m <= comparator2_out;
         cmp_s <= cmp_m;
         on_d <= ctl.timer_on;
      end
   end

   always_comb
   begin
      ext_rise = ext_s & ~ext_d; // see [R3]
      ext_fall = ~ext_s & ext_d;
      wr_any = count_write.wr_high | count_write.wr_low;
      // Instruction clock is a quarter of sys_clk and stops in sleep
      next_cy_div = sleep_mode ? cy_div : cy_div + 2'h1;
      cy_en = !sleep_mode && (cy_div == gtc_pkg::INSTR_LAST);
      gate_act = gate_source_select ? cmp_s : gpin_s; // see [R15]
      gate_act = ctl.gate_invert ? gate_act : ~gate_act; // see [R17] [R25]
      gate_ok = !ctl.gate_enable || gate_act; // see [R16]
      // Falling edge arming for counter mode
      next_first_on = first_on && !(ctl.timer_on && !on_d);
      next_lvl_off = (on_d && !ctl.timer_on) ? ext_s : lvl_off;
      next_armed = armed;
      if (ext_fall)
         next_armed = 1'b1;
      if (ctl.timer_on && !on_d && (first_on || (lvl_off && !ext_s)))
         next_armed = 1'b0; // see [R4]
      if (wr_any)
         next_armed = 1'b0; // see [R4]
      // Synchronous mode holds an edge until the next instruction cycle
      next_sync_pend = sync_pend;
      if (ext_rise && armed && !sleep_mode)
         next_sync_pend = 1'b1; // see [R22]
      if (cy_en || ctl.sync_bypass || wr_any)
         next_sync_pend = 1'b0; // see [R12]
      if (!ctl.count_source_select)
         src_tick = cy_en; // see [R2]
      else if (ctl.sync_bypass)
         src_tick = ext_rise && armed; // see [R11]
      else
         src_tick = cy_en && (sync_pend || (ext_rise && armed));
      sleep_ok = !sleep_mode || (ctl.count_source_select && ctl.sync_bypass); // see [R22]
      presc_tick = ctl.timer_on && gate_ok && sleep_ok && src_tick; // see [R24]
      next_presc = presc;
      inc = 1'b0;
      if (presc_tick)
      begin
         if (presc >= presc_last(ctl.prescale_select)) // see [R5] [R23]
         begin
            next_presc = gtc_pkg::PRESC_RESET;
            inc = 1'b1;
         end
         else
            next_presc = presc + 3'h1;
      end
      next_count = count;
      if (inc)
         next_count = count + 16'h0001; // see [R18]
      // A write wins over a coincident increment in the byte it writes
      if (count_write.wr_high)
         next_count[15:8] = count_write.wr_data; // see [R1]
      if (count_write.wr_low)
         next_count[7:0] = count_write.wr_data; // see [R1]
      if (wr_any)
         next_presc = gtc_pkg::PRESC_RESET; // see [R6]
      // Set wins over a coincident clear
      next_flag = flag && !irq_control.flag_clear;
      if (inc && count == gtc_pkg::COUNT_TOP)
         next_flag = 1'b1; // see [R18] [R20]
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count <= gtc_pkg::COUNT_RESET;
         presc <= gtc_pkg::PRESC_RESET;
         cy_div <= 2'h0;
         armed <= 1'b0;
         first_on <= 1'b1;
         lvl_off <= 1'b0;
         sync_pend <= 1'b0;
         flag <= 1'b0;
      end
      else
      begin
         count <= next_count;
         presc <= next_presc;
         cy_div <= next_cy_div;
         armed <= next_armed;
         first_on <= next_first_on;
         lvl_off <= next_lvl_off;
         sync_pend <= next_sync_pend;
         flag <= next_flag;
      end
   end

   // Both bytes come from one register, so a read is never torn mid-update
   assign count_high_byte = count[15:8]; // see [R13]
   assign count_low_byte = count[7:0]; // see [R13]
   assign rollover_flag = flag;
   assign irq_request = flag && irq_control.rollover_irq_enable // see [R19]
      && irq_control.periph_irq_enable && irq_control.global_irq_enable;
   assign wake_request = sleep_mode && ctl.timer_on && flag // see [R22]
      && irq_control.rollover_irq_enable && irq_control.periph_irq_enable;
   // Oscillator is not gated by sleep, only by the enable and clock mode
   assign crystal_osc_run = ctl.crystal_osc_enable && main_clk_lp_compatible; // see [R7] [R8]
   assign osc_out_pin_direction = crystal_osc_run || osc_out_pin_direction_sw; // see [R9]
   assign osc_in_pin_direction = crystal_osc_run || osc_in_pin_direction_sw; // see [R9]
   assign osc_out_port_bit = !crystal_osc_run && osc_out_port_bit_pin; // see [R9]
   assign osc_in_port_bit = !crystal_osc_run && osc_in_port_bit_pin; // see [R9]

   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence wrap_seq;
      inc && count == gtc_pkg::COUNT_TOP && !wr_any;
   endsequence
   sequence flag_seq;
      count == gtc_pkg::COUNT_RESET && flag;
   endsequence

   rollover_wrap_a: assert property (wrap_seq |=> flag_seq) // see [R18]
      else $error("rollover did not wrap or set flag");
   low_write_a: assert property (count_write.wr_low |=> count[7:0] == $past(count_write.wr_data)) // see [R1]
      else $error("low byte write lost");
   high_write_a: assert property (count_write.wr_high |=> count[15:8] == $past(count_write.wr_data)) // see [R1]
      else $error("high byte write lost");
   off_hold_a: assert property (!ctl.timer_on && !wr_any |=> count == $past(count)) // see [R24]
      else $error("counter moved while off");
   presc_clear_a: assert property (wr_any |=> presc == gtc_pkg::PRESC_RESET && !armed) // see [R6] [R4]
      else $error("write did not clear prescaler or arming");
   gate_block_a: assert property (ctl.gate_enable && !gate_act |-> !inc) // see [R16] [R25]
      else $error("count through closed gate");
   sleep_sync_a: assert property (sleep_mode && !ctl.sync_bypass |-> !inc) // see [R22]
      else $error("sync mode counted in sleep");
   internal_tick_a: assert property (!ctl.count_source_select && inc |-> cy_en) // see [R2]
      else $error("internal count off instruction cycle");
   div_two_a: assert property (ctl.prescale_select == gtc_pkg::PS_DIV2 && inc |-> presc_tick && presc == 3'h1) // see [R5]
      else $error("divide by two miscounts");
   flag_hold_a: assert property (flag && !irq_control.flag_clear |=> flag [*2] or ##1 !flag && $past(irq_control.flag_clear)) // see [R20]
      else $error("flag cleared itself");
   irq_all_a: assert property (irq_request |-> flag && irq_control.global_irq_enable) // see [R19]
      else $error("interrupt without enables");
   osc_pins_a: assert property (crystal_osc_run |-> osc_out_pin_direction && !osc_in_port_bit) // see [R9]
      else $error("oscillator pins not forced");

   // Arming and edge capture steps for counter mode
   sequence ext_edge_seq;
      ctl.count_source_select && ctl.sync_bypass && ext_rise && armed;
   endsequence
   sequence write_seq;
      wr_any;
   endsequence
   sequence unarmed_seq;
      !armed;
   endsequence

   async_edge_a: assert property (ext_edge_seq |-> presc_tick || !ctl.timer_on || !gate_ok) // see [R11]
      else $error("async edge not counted");
   write_unarm_a: assert property (write_seq |=> unarmed_seq) // see [R4]
      else $error("write left edge armed");
   unarmed_count_a: assert property (ctl.count_source_select && ctl.sync_bypass && !armed |-> !src_tick) // see [R4]
      else $error("counted before falling edge");
   first_on_a: assert property (ctl.timer_on && !on_d && first_on |=> !armed) // see [R4]
      else $error("first enable left edge armed");
   sleep_pend_a: assert property (sleep_mode |=> !sync_pend || $past(sync_pend)) // see [R22]
      else $error("edge captured in sleep");
   wake_gate_a: assert property (wake_request |-> sleep_mode && flag && ctl.timer_on) // see [R22]
      else $error("wake without overflow");
   src_select_a: assert property (ctl.count_source_select && !ctl.sync_bypass && src_tick |-> cy_en) // see [R3]
      else $error("sync edge off instruction cycle");
   div_one_a: assert property (ctl.prescale_select == gtc_pkg::PS_DIV1 && presc_tick |-> inc) // see [R23]
      else $error("divide by one miscounts");
   div_eight_a: assert property (ctl.prescale_select == gtc_pkg::PS_DIV8 && inc |-> presc == 3'h7) // see [R23]
      else $error("divide by eight miscounts");
   idle_presc_a: assert property (!presc_tick && !wr_any |=> presc == $past(presc)) // see [R6]
      else $error("prescaler moved without tick");
   gate_open_a: assert property (!ctl.gate_enable |-> gate_ok) // see [R16]
      else $error("gate acted while disabled");
   invert_flip_a: assert property (ctl.gate_invert |-> gate_act == (gate_source_select ? cmp_s : gpin_s)) // see [R17]
      else $error("gate invert wrong");
   flag_set_a: assert property (inc && count == gtc_pkg::COUNT_TOP |=> flag) // see [R18]
      else $error("rollover flag not set");
   irq_off_a: assert property (!irq_control.global_irq_enable |-> !irq_request) // see [R19]
      else $error("interrupt without global enable");
   osc_dir_a: assert property (crystal_osc_run |-> osc_in_pin_direction && !osc_out_port_bit) // see [R9]
      else $error("oscillator pins not forced");
   osc_enable_a: assert property (crystal_osc_run |-> ctl.crystal_osc_enable && main_clk_lp_compatible) // see [R7] [R8]
      else $error("oscillator ran without enable");
endmodule : gtc_timer

// ---- src/gtc_pkg.sv ----
// Shared constants and carriers for the gated 16-bit timer/counter
package gtc_pkg;
   localparam int COUNT_W = 16;
   localparam int PRESC_W = 3;
   localparam int INSTR_DIV = 4;
   localparam logic [1:0] INSTR_LAST = 2'h3;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_TOP = 16'hFFFF;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [2:0] PRESC_RESET = 3'h0;
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV2 = 2'h1;
   localparam logic [1:0] PS_DIV4 = 2'h2;
   localparam logic [1:0] PS_DIV8 = 2'h3;

   // Control byte, bit 7 down to bit 0
   typedef struct packed {
      logic gate_invert;
      logic gate_enable;
      logic [1:0] prescale_select;
      logic crystal_osc_enable;
      logic sync_bypass;
      logic count_source_select;
      logic timer_on;
   } gtc_ctrl_s;

   // Interrupt enables and flag clear from the core
   typedef struct packed {
      logic rollover_irq_enable;
      logic periph_irq_enable;
      logic global_irq_enable;
      logic flag_clear;
   } gtc_irq_s;

   // Software write strobes to the count pair
   typedef struct packed {
      logic wr_high;
      logic wr_low;
      logic [7:0] wr_data;
   } gtc_wr_s;
endpackage : gtc_pkg

// ---- verification/gtc_pin_model.sv ----
// External count source that drives the count pin with whole pulses
`timescale 1ns/100ps
module gtc_pin_model
(
   // Clock
   input wire logic sys_clk,
   // Count pin
   output logic count_pin
);
   initial count_pin = 1'b0;
   // Each pulse rises then falls, high three clocks and low four
   task automatic pulse(input int n);
      repeat (n)
      begin
         @(posedge sys_clk) #1;
         count_pin = 1'b1;
         repeat (3) @(posedge sys_clk);
         #1;
         count_pin = 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask : pulse
endmodule : gtc_pin_model

// ---- verification/tb_gtc_timer.sv ----
// Self-checking bench for the gated 16-bit timer/counter
`timescale 1ns/100ps
module tb_gtc_timer;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   gtc_pkg::gtc_ctrl_s ctl = gtc_pkg::CTRL_RESET;
   gtc_pkg::gtc_wr_s cw = '0;
   gtc_pkg::gtc_irq_s irq = '0;
   logic sleep_mode = 1'b0;
   logic compat = 1'b0;
   logic gsel = 1'b0;
   logic gpin = 1'b0;
   logic cmp = 1'b0;
   logic [3:0] osc_sw = 4'h0;
   logic ext_pin;
   logic [7:0] hi, lo;
   logic flag, irq_req, wake, osc_run, dout, din, pout, pin;
   logic [15:0] cnt, c0;
   int num_errors = 0;
   int n_compared = 0;
   assign cnt = {hi, lo};
   always #2 sys_clk = ~sys_clk;
   gtc_pin_model u_pins (.sys_clk(sys_clk), .count_pin(ext_pin));
   gtc_timer i_gtc_timer
   (
      .sys_clk(sys_clk), .reset_n(reset_n), .timer_control_reg(ctl), .count_write(cw), .irq_control(irq),
      .sleep_mode(sleep_mode), .main_clk_lp_compatible(compat), .gate_source_select(gsel),
      .osc_out_pin_direction_sw(osc_sw[3]), .osc_in_pin_direction_sw(osc_sw[2]),
      .osc_out_port_bit_pin(osc_sw[1]), .osc_in_port_bit_pin(osc_sw[0]), .external_count_input(ext_pin),
      .gate_input_pin(gpin), .comparator2_out(cmp), .count_high_byte(hi), .count_low_byte(lo),
      .rollover_flag(flag), .irq_request(irq_req), .wake_request(wake), .crystal_osc_run(osc_run),
      .osc_out_pin_direction(dout), .osc_in_pin_direction(din), .osc_out_port_bit(pout), .osc_in_port_bit(pin)
   );
   task conclude;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task wr(input logic h, input logic [7:0] d);
      @(posedge sys_clk) #1;
      cw = '{wr_high: h, wr_low: !h, wr_data: d};
      @(posedge sys_clk) #1;
      cw = '0;
   endtask : wr
   // Count advance over a window of n edges, after the inputs settle
   task meas(input int n, input logic [15:0] e);
      cyc(8);
      c0 = cnt;
      cyc(n);
      chk("delta", e, cnt - c0);
   endtask : meas
   initial
   begin
      #40000;
      num_errors++;
      conclude();
   end
   initial
   begin
      cyc(4);
      reset_n = 1'b1;
      chk("reset", 16'h0000, {7'h00, flag, cnt[15:8] | cnt[7:0]});
      wr(1'b1, 8'hA5);
      wr(1'b0, 8'h5A);
      chk("count", 16'hA55A, cnt);
      gpin = 1'b1;
      ctl.timer_on = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         ctl.prescale_select = i[1:0];
         meas(128, 16'(32 >> i));
      end
      ctl.timer_on = 1'b0;
      meas(64, 16'h0000);
      ctl.timer_on = 1'b1;
      cyc(20);
      wr(1'b0, 8'h00);
      cyc(26);
      chk("low", 16'h0000, lo);
      cyc(8);
      chk("low", 16'h0001, lo);
      ctl.prescale_select = gtc_pkg::PS_DIV1;
      ctl.gate_enable = 1'b1;
      meas(64, 16'h0000);
      ctl.gate_invert = 1'b1;
      meas(64, 16'h0010);
      gsel = 1'b1;
      ctl.gate_invert = 1'b0;
      meas(64, 16'h0010);
      cmp = 1'b1;
      meas(64, 16'h0000);
      ctl = gtc_pkg::CTRL_RESET;
      wr(1'b1, 8'hFF);
      wr(1'b0, 8'hFF);
      irq = '{rollover_irq_enable: 1'b1, periph_irq_enable: 1'b1, global_irq_enable: 1'b0, flag_clear: 1'b0};
      ctl.timer_on = 1'b1;
      cyc(8);
      chk("high", 16'h0000, hi);
      chk("flag", 16'h0001, flag);
      chk("irq", 16'h0000, irq_req);
      irq.global_irq_enable = 1'b1;
      cyc(1);
      chk("irq", 16'h0001, irq_req);
      sleep_mode = 1'b1;
      cyc(1);
      chk("wake", 16'h0001, wake);
      irq.flag_clear = 1'b1;
      cyc(1);
      irq.flag_clear = 1'b0;
      cyc(1);
      chk("flag", 16'h0000, flag);
      sleep_mode = 1'b0;
      ctl = 8'h06;
      wr(1'b1, 8'h00);
      wr(1'b0, 8'h00);
      ctl.timer_on = 1'b1;
      u_pins.pulse(3);
      cyc(10);
      chk("ext", 16'h0002, cnt);
      sleep_mode = 1'b1;
      u_pins.pulse(2);
      cyc(10);
      chk("ext", 16'h0004, cnt);
      ctl.sync_bypass = 1'b0;
      u_pins.pulse(2);
      cyc(10);
      chk("ext", 16'h0004, cnt);
      sleep_mode = 1'b0;
      u_pins.pulse(2);
      cyc(12);
      chk("ext", 16'h0006, cnt);
      ctl.timer_on = 1'b0;
      ctl.crystal_osc_enable = 1'b1;
      compat = 1'b1;
      osc_sw = 4'h3;
      cyc(1);
      chk("osc", 16'h001C, {osc_run, dout, din, pout, pin});
      compat = 1'b0;
      cyc(1);
      chk("osc", 16'h0003, {osc_run, dout, din, pout, pin});
      conclude();
   end
endmodule : tb_gtc_timer
